// ===== hdl/msd_pkg.sv
// Constants, register map and carrier types of the memory scan debug block
package msd_pkg;
    // Register indices as printed; byte address is four times the index
    localparam logic [11:0] IDX_CRC_DATA   = 12'hF3F;
    localparam logic [11:0] IDX_CRC_ACC    = 12'hF41;
    localparam logic [11:0] IDX_CRC_SHIFT  = 12'hF43;
    localparam logic [11:0] IDX_CRC_POLY   = 12'hF45;
    localparam logic [11:0] IDX_CRC_CTRL   = 12'hF47;
    localparam logic [11:0] IDX_CRC_LEN    = 12'hF48;
    localparam logic [11:0] IDX_SCAN_START = 12'hF49;
    localparam logic [11:0] IDX_SCAN_END   = 12'hF4C;
    localparam logic [11:0] IDX_SCAN_CTRL  = 12'hF4F;
    localparam logic [11:0] IDX_SCAN_TRIG  = 12'hF50;
    // Registers of our own: module disable, interrupt status and mask
    localparam logic [11:0] IDX_MOD_DIS    = 12'hF60;
    localparam logic [11:0] IDX_IRQ_STAT   = 12'hF61;
    localparam logic [11:0] IDX_IRQ_MASK   = 12'hF62;
    // Scanner control bit positions
    localparam int SC_EN      = 7;
    localparam int SC_GO      = 6;
    localparam int SC_BUSY    = 5;
    localparam int SC_INVALID = 4;
    localparam int SC_INTM    = 3;
    // CRC control bit positions
    localparam int CC_EN = 7;
    localparam int CC_GO = 6;
    // Module disable bit positions
    localparam int MD_CRC  = 0;
    localparam int MD_SCAN = 1;
    // Interrupt status bits
    localparam int IRQ_DONE  = 0;
    localparam int IRQ_ABORT = 1;
    localparam int IRQ_W     = 2;
    // Reset values, address step and address write mask
    localparam logic [7:0]  SCAN_CTRL_RST = 8'h10;
    localparam logic [15:0] POLY_RST      = 16'h0001;
    localparam logic [23:0] ADDR_ONE      = 24'h000001;
    localparam logic [23:0] ADDR_MASK     = 24'h3FFFFF;
    // Scan mode encoding
    typedef enum logic [1:0] {
        MODE_CONC  = 2'b00,
        MODE_BURST = 2'b01,
        MODE_PEEK  = 2'b10,
        MODE_TRIG  = 2'b11
    } msd_mode_type;
    // Scanner sequencing states
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_WAIT   = 2'b01,
        ST_ACCESS = 2'b10,
        ST_DEFER  = 2'b11
    } msd_state_type;
    // Debug events from the core
    typedef struct packed {
        logic ext_halt;   // External halt request
        logic pc_bp;      // Program counter breakpoint
        logic data_bp;    // Data breakpoint hit this cycle
        logic step;       // Single step in progress
        logic sw_bp;      // Software breakpoint fetched
        logic in_debug;   // Core sits in debug mode
    } msd_dbg_type;
    // Core pipeline status
    typedef struct packed {
        logic go_instr;   // Current instruction sets the go bit
        logic dead_cycle; // Core leaves the memory free this cycle
        logic instr_ok;   // Current instruction will execute
    } msd_core_type;
endpackage

// ===== hdl/msd_scan_ctrl.sv
// Memory scanner with debug freeze, module disable and APB registers
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module msd_scan_ctrl
    import msd_pkg::*;
#(
    parameter int AW = 24  // Program memory address width
) (
    input  wire logic               REF_CLK,
    input  wire logic               RST,
    input  wire logic               PSEL,
    input  wire logic               PENABLE,
    input  wire logic               PWRITE,
    input  wire logic [15:0]        PADDR,
    input  wire logic [31:0]        PWDATA,
    output logic      [31:0]        PRDATA,
    output logic                    PREADY,
    output logic                    PSLVERR,
    input  wire logic               SWEEP_CONFIG_ALLOW,
    input  wire msd_dbg_type        DBG,
    input  wire msd_core_type       CORE,
    input  wire logic               TRIG_IN,
    input  wire logic               CRC_READY,
    input  wire logic               ADDR_IMPL,
    output logic                    FLASH_RD,
    output logic      [AW-1:0]      FLASH_ADDR,
    output logic                    CPU_STALL,
    output logic                    IRQ
);
    // Register state
    logic [7:0]    scan_ctrl;        // Scanner control
    logic [7:0]    crc_ctrl;         // CRC control
    logic [7:0]    crc_len;          // CRC lengths
    logic [15:0]   crc_data;         // CRC data port
    logic [15:0]   crc_acc;          // Accumulator
    logic [15:0]   crc_poly;         // Polynomial terms
    logic [7:0]    trig_sel;         // Trigger source
    logic [AW-1:0] addr;             // Current / start address
    logic [AW-1:0] end_addr;         // End address
    logic [1:0]    mod_dis;          // Module disable bits
    logic [IRQ_W-1:0] irq_stat;      // Sticky events
    logic [IRQ_W-1:0] irq_mask;      // Event mask
    msd_state_type state;            // Sequencer state
    logic          trig_d;           // Trigger delayed
    logic          burst_pend;       // Burst deferred to debug exit
    logic          peek_pend;        // Peek owed to skipped instruction
    // Next values
    logic [7:0]    next_scan_ctrl;
    logic [7:0]    next_crc_ctrl;
    logic [7:0]    next_crc_len;
    logic [15:0]   next_crc_data;
    logic [15:0]   next_crc_acc;
    logic [15:0]   next_crc_poly;
    logic [7:0]    next_trig_sel;
    logic [AW-1:0] next_addr;
    logic [AW-1:0] next_end_addr;
    logic [1:0]    next_mod_dis;
    logic [IRQ_W-1:0] next_irq_stat;
    logic [IRQ_W-1:0] next_irq_mask;
    msd_state_type next_state;
    logic          next_burst_pend;
    logic          next_peek_pend;
    logic          next_flash_rd;
    logic [31:0]   next_prdata;
    // Decoded helpers
    logic          wr;               // Write completes this cycle
    logic          rd;               // Read set up this cycle
    logic [11:0]   idx;              // Register index
    logic          scan_off;         // Scanner switched off
    logic          crc_off;          // CRC switched off
    logic          go;               // Go bit
    msd_mode_type  mode;             // Scan mode
    logic          frozen;           // Debug freeze
    logic          ext_halt_now;     // External halt this cycle
    logic          slot;             // Memory slot free for scan
    logic          last;             // Access ends the scan
    logic          trig_rise;        // Trigger rising edge
    logic          go_ok;            // Scanner allowed to run

    // Index of a register from a byte address
    function automatic logic [11:0] reg_index(input logic [15:0] a);
        reg_index = a[13:2];
    endfunction

    // Known register test
    function automatic logic mapped(input logic [11:0] i);
        case (i)
            IDX_CRC_DATA, IDX_CRC_ACC, IDX_CRC_SHIFT, IDX_CRC_POLY,
            IDX_CRC_CTRL, IDX_CRC_LEN, IDX_SCAN_START, IDX_SCAN_END,
            IDX_SCAN_CTRL, IDX_SCAN_TRIG, IDX_MOD_DIS, IDX_IRQ_STAT,
            IDX_IRQ_MASK: mapped = 1'b1;
            default:      mapped = 1'b0;
        endcase
    endfunction

    // Bus decode and status terms
    always_comb begin
        idx       = reg_index(PADDR);
        wr        = PSEL && PENABLE && PWRITE;
        // Read data is fetched in the setup cycle so it stands at the
        // access edge, where the master takes it
        rd        = PSEL && !PENABLE && !PWRITE;
        // Scanner disable honoured only with the allow bit
        scan_off  = !SWEEP_CONFIG_ALLOW
                    || (SWEEP_CONFIG_ALLOW && mod_dis[MD_SCAN]);
        crc_off   = mod_dis[MD_CRC];
        go        = scan_ctrl[SC_GO];
        mode      = msd_mode_type'(scan_ctrl[1:0]);
        frozen    = DBG.in_debug;
        ext_halt_now = DBG.ext_halt;
        go_ok     = !scan_off && !crc_off && scan_ctrl[SC_EN]
                    && crc_ctrl[CC_EN] && crc_ctrl[CC_GO];
        trig_rise = TRIG_IN && !trig_d;
        last      = (addr == end_addr) || !ADDR_IMPL;
        // Slot rules per mode
        case (mode)
            MODE_PEEK:  slot = CORE.dead_cycle || peek_pend;
            MODE_BURST: slot = 1'b1;
            default:    slot = 1'b1;
        endcase
    end

    // Answer signals
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped(idx);

    // Scanner sequencing and register writes
    always_comb begin
        next_scan_ctrl  = scan_ctrl;
        next_crc_ctrl   = crc_ctrl;
        next_crc_len    = crc_len;
        next_crc_data   = crc_data;
        next_crc_acc    = crc_acc;
        next_crc_poly   = crc_poly;
        next_trig_sel   = trig_sel;
        next_addr       = addr;
        next_end_addr   = end_addr;
        next_mod_dis    = mod_dis;
        next_irq_stat   = irq_stat;
        next_irq_mask   = irq_mask;
        next_state      = state;
        next_burst_pend = burst_pend;
        next_peek_pend  = peek_pend;
        next_flash_rd   = 1'b0;
        // Register writes from software
        if (wr) begin
            case (idx)
                IDX_CRC_DATA:   next_crc_data = PWDATA[15:0];
                IDX_CRC_ACC:    next_crc_acc  = PWDATA[15:0];
                IDX_CRC_POLY:   next_crc_poly = PWDATA[15:0] | POLY_RST;
                IDX_CRC_CTRL:   next_crc_ctrl = {PWDATA[7:6], 1'b0,
                                    PWDATA[4], 2'b00, PWDATA[1], 1'b0};
                IDX_CRC_LEN:    next_crc_len  = PWDATA[7:0];
                IDX_SCAN_START: next_addr     = PWDATA[AW-1:0] & ADDR_MASK;
                IDX_SCAN_END:   next_end_addr = PWDATA[AW-1:0] & ADDR_MASK;
                IDX_SCAN_CTRL:  next_scan_ctrl = {PWDATA[7:6],
                                    scan_ctrl[5:4], PWDATA[3], 1'b0,
                                    PWDATA[1:0]};
                IDX_SCAN_TRIG:  next_trig_sel = {4'h0, PWDATA[3:0]};
                IDX_MOD_DIS:    next_mod_dis  = PWDATA[1:0];
                IDX_IRQ_STAT:   next_irq_stat = irq_stat & ~PWDATA[IRQ_W-1:0];
                IDX_IRQ_MASK:   next_irq_mask = PWDATA[IRQ_W-1:0];
                default:        next_mod_dis  = mod_dis;
            endcase
            // Go written in burst while a halt, step, PC or software breakpoint lands
            if (idx == IDX_SCAN_CTRL && PWDATA[SC_GO] && !go
                && mode == MODE_BURST
                && (ext_halt_now || DBG.pc_bp || DBG.step || DBG.sw_bp))
                next_burst_pend = 1'b1;
        end
        // Abort when enables drop
        if (go && !go_ok) begin
            next_scan_ctrl[SC_GO]      = 1'b0;
            next_scan_ctrl[SC_INVALID] = 1'b1;
            next_state                 = ST_IDLE;
            next_irq_stat[IRQ_ABORT]   = 1'b1;
        end else if (frozen) begin
            // Sequencer held while debug owns the core; software register writes still land
            next_state = state;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (go && (mode != MODE_TRIG)) begin
                        next_scan_ctrl[SC_INVALID] = 1'b0;
                        next_state = ST_WAIT;
                    end else if (go && trig_rise) begin
                        next_scan_ctrl[SC_INVALID] = 1'b0;
                        next_state = ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // Outside burst mode, a halt just before a scan cycle defers it
                    // Outside burst mode, a data breakpoint postpones same-cycle scan
                    if (burst_pend) begin
                        next_burst_pend = 1'b0;         // Exit reached
                    end else if (mode != MODE_BURST
                        && (ext_halt_now || DBG.data_bp)) begin
                        next_state = ST_DEFER;
                    end else if (mode == MODE_PEEK && !CORE.instr_ok
                        && CORE.dead_cycle) begin
                        next_peek_pend = 1'b1;
                    end else if (CRC_READY && slot) begin
                        // PC, step and software breakpoints wait
                        next_flash_rd = 1'b1;
                        next_peek_pend = 1'b0;
                        next_state = ST_ACCESS;
                    end
                end
                ST_ACCESS: begin
                    // Access in flight completes unless the enables drop
                    next_crc_data = FLASH_ADDR[15:0];
                    if (last) begin
                        next_scan_ctrl[SC_GO] = 1'b0;
                        next_irq_stat[IRQ_DONE] = 1'b1;
                        next_state = ST_IDLE;
                    end else begin
                        next_addr  = addr + ADDR_ONE[AW-1:0];
                        next_state = ST_WAIT;
                    end
                end
                ST_DEFER: next_state = ST_WAIT;         // Resume at exit
                default:  next_state = ST_IDLE;
            endcase
        end
        // Software clearing go ends the scan early
        if (!next_scan_ctrl[SC_GO] && state != ST_ACCESS) begin
            next_state    = ST_IDLE;
            next_flash_rd = 1'b0;           // No read once go is gone
        end
        next_scan_ctrl[SC_BUSY] = (next_state != ST_IDLE);
    end

    // Read data mux; the word fetched in setup stands through access
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (PSEL && PENABLE) begin
            next_prdata = PRDATA;           // Hold across the access edge
        end else if (rd) begin
            case (idx)
                IDX_CRC_DATA:   next_prdata = {16'h0000, crc_data};
                IDX_CRC_ACC:    next_prdata = {16'h0000, crc_acc};
                IDX_CRC_SHIFT:  next_prdata = {16'h0000, crc_data};
                IDX_CRC_POLY:   next_prdata = {16'h0000, crc_poly};
                IDX_CRC_CTRL:   next_prdata = {24'h000000, crc_ctrl};
                IDX_CRC_LEN:    next_prdata = {24'h000000, crc_len};
                IDX_SCAN_START: next_prdata = {{(32-AW){1'b0}}, addr};
                IDX_SCAN_END:   next_prdata = {{(32-AW){1'b0}}, end_addr};
                IDX_SCAN_CTRL:  next_prdata = {24'h000000, scan_ctrl};
                IDX_SCAN_TRIG:  next_prdata = {24'h000000, trig_sel};
                IDX_MOD_DIS:    next_prdata = {30'h0, mod_dis};
                IDX_IRQ_STAT:   next_prdata = {30'h0, irq_stat};
                IDX_IRQ_MASK:   next_prdata = {30'h0, irq_mask};
                default:        next_prdata = 32'h0000_0000;
            endcase
        end
    end

    // Registers
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            scan_ctrl  <= SCAN_CTRL_RST;
            crc_ctrl   <= 8'h00;
            crc_len    <= 8'h00;
            crc_data   <= 16'h0000;
            crc_acc    <= 16'h0000;
            crc_poly   <= POLY_RST;
            trig_sel   <= 8'h00;
            addr       <= '0;
            end_addr   <= '0;
            mod_dis    <= 2'b00;
            irq_stat   <= '0;
            irq_mask   <= '0;
            state      <= ST_IDLE;
            trig_d     <= 1'b0;
            burst_pend <= 1'b0;
            peek_pend  <= 1'b0;
            FLASH_RD   <= 1'b0;
            PRDATA     <= 32'h0000_0000;
        end else begin
            scan_ctrl  <= next_scan_ctrl;
            crc_ctrl   <= next_crc_ctrl;
            crc_len    <= next_crc_len;
            crc_data   <= next_crc_data;
            crc_acc    <= next_crc_acc;
            crc_poly   <= next_crc_poly;
            trig_sel   <= next_trig_sel;
            addr       <= next_addr;
            end_addr   <= next_end_addr;
            mod_dis    <= next_mod_dis;
            irq_stat   <= next_irq_stat;
            irq_mask   <= next_irq_mask;
            state      <= next_state;
            trig_d     <= TRIG_IN;
            burst_pend <= next_burst_pend;
            peek_pend  <= next_peek_pend;
            FLASH_RD   <= next_flash_rd;
            PRDATA     <= next_prdata;
        end
    end

    // Outputs
    assign FLASH_ADDR = addr;
    assign IRQ        = |(irq_stat & irq_mask);
    // Burst stalls throughout unless deferred; peek never stalls; other modes only while reading
    assign CPU_STALL  = (state != ST_IDLE) && !frozen
                        && (mode == MODE_BURST ? !burst_pend
                            : (mode != MODE_PEEK && state == ST_ACCESS));
endmodule
`default_nettype wire

// ===== test/msd_scan_ctrl_properties.sv
// Concurrent checks of the memory scan debug block
`timescale 1ns/1ps
`default_nettype none
module msd_scan_ctrl_properties
    import msd_pkg::*;
#(
    parameter int AW = 24
) (
    input wire logic          REF_CLK,
    input wire logic          RST,
    input wire logic          PSEL,
    input wire logic          PENABLE,
    input wire logic          PWRITE,
    input wire logic [15:0]   PADDR,
    input wire logic [31:0]   PWDATA,
    input wire logic          SWEEP_CONFIG_ALLOW,
    input wire msd_dbg_type   DBG,
    input wire logic          ADDR_IMPL,
    input wire logic          FLASH_RD,
    input wire logic [AW-1:0] FLASH_ADDR,
    input wire logic          IRQ
);
    logic       wr;            // APB write taking effect
    logic       off;           // Scanner disable bit as written
    logic       next_off;
    logic [1:0] mode;          // Scan mode as written
    logic [1:0] next_mode;
    assign wr = PSEL && PENABLE && PWRITE;
    // Shadow of the disable bit and mode field
    always_comb begin
        next_off = off;
        next_mode = mode;
        if (wr && PADDR[13:2] == IDX_MOD_DIS) next_off = PWDATA[MD_SCAN];
        if (wr && PADDR[13:2] == IDX_SCAN_CTRL) next_mode = PWDATA[1:0];
    end
    always_ff @(posedge REF_CLK) begin
        off <= RST ? 1'b0 : next_off;
        mode <= RST ? 2'b00 : next_mode;
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    debug_no_read_a: assert property (DBG.in_debug |=> !FLASH_RD)
        else $error("flash read while in debug");
    debug_addr_hold_a: assert property (
        DBG.in_debug |=> $stable(FLASH_ADDR))
        else $error("scan address moved in debug");
    cfg_off_a: assert property (!SWEEP_CONFIG_ALLOW |=> !FLASH_RD)
        else $error("scanner read while unavailable");
    module_off_a: assert property (
        off && SWEEP_CONFIG_ALLOW |=> !FLASH_RD)
        else $error("disabled scanner read");
    halt_defer_a: assert property (
        DBG.ext_halt && mode != MODE_BURST |=> !FLASH_RD)
        else $error("scan not deferred by halt");
    dbp_defer_a: assert property (
        DBG.data_bp && mode != MODE_BURST |=> !FLASH_RD)
        else $error("scan not postponed by data break");
    read_pulse_a: assert property (FLASH_RD |=> !FLASH_RD)
        else $error("flash read longer than one cycle");
    done_stop_a: assert property (
        FLASH_RD && !ADDR_IMPL |=> !FLASH_RD [*8])
        else $error("scan went on past unimplemented address");
    cover property (DBG.in_debug ##1 !DBG.in_debug ##[1:50] FLASH_RD);
    cover property (FLASH_RD && !ADDR_IMPL);
    cover property (IRQ);
endmodule
bind msd_scan_ctrl msd_scan_ctrl_properties #(.AW(AW)) i_props (
    .REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .DBG(DBG),
    .SWEEP_CONFIG_ALLOW(SWEEP_CONFIG_ALLOW), .ADDR_IMPL(ADDR_IMPL),
    .FLASH_RD(FLASH_RD), .FLASH_ADDR(FLASH_ADDR), .IRQ(IRQ));
`default_nettype wire

// ===== test/msd_core_model.sv
// Behavioural core with debug halt, breakpoints and stepping
`timescale 1ns/1ps
`default_nettype none
module msd_core_model
    import msd_pkg::*;
(
    input  wire logic       REF_CLK,
    input  wire logic       RST,
    input  wire logic       CPU_STALL,
    input  wire logic [2:0] evt_kind,  // 0 halt, 1 pc, 2 data, 3 step, 4 sw
    input  wire logic       evt_req,   // One-cycle debug event request
    output msd_dbg_type     DBG,
    output msd_core_type    CORE
);
    logic [7:0] cnt;    // Debug cycles left
    logic [1:0] phase;  // Instruction slot, slot 3 leaves memory free
    // Event for one cycle, then a fixed stay in debug
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            cnt <= 8'h00;
            phase <= 2'h0;
            DBG <= '0;
        end else begin
            phase <= phase + 2'h1;
            DBG <= '0;
            DBG.in_debug <= cnt != 8'h00;
            cnt <= (cnt != 8'h00) ? cnt - 8'h01 : 8'h00;
            if (evt_req) begin
                DBG.ext_halt <= evt_kind == 3'h0;
                DBG.pc_bp <= evt_kind == 3'h1;
                DBG.data_bp <= evt_kind == 3'h2;
                DBG.step <= evt_kind == 3'h3;
                DBG.sw_bp <= evt_kind == 3'h4;
                cnt <= 8'h14;
            end
        end
    end
    // Go instruction never flagged; slot 3 is the dead cycle
    assign CORE = msd_core_type'({1'b0, phase == 2'h3 && !DBG.in_debug,
                                  !CPU_STALL && !DBG.in_debug});
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Self-checking testbench of the memory scan debug block
`timescale 1ns/1ps
`default_nettype none
module testbench
    import msd_pkg::*;
;
    logic        clk, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic        pready, pslverr, err, flash_rd, stall, irq;
    logic        allow = 1'b1, trig = 1'b0, impl = 1'b1, evt_req = 1'b0;
    logic [2:0]  kind = 3'h0;
    logic [23:0] flash_addr, last_a = 24'h0, a0;
    logic        seq = 1'b0;
    int          n_fail = 0, checks_done = 0, n_rd = 0, n0;
    msd_dbg_type  dbg;
    msd_core_type core;
    msd_scan_ctrl i_msd_scan_ctrl (.REF_CLK(clk), .RST(rst), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .SWEEP_CONFIG_ALLOW(allow), .DBG(dbg), .CORE(core), .TRIG_IN(trig),
        .CRC_READY(1'b1), .ADDR_IMPL(impl), .FLASH_RD(flash_rd),
        .FLASH_ADDR(flash_addr), .CPU_STALL(stall), .IRQ(irq));
    msd_core_model i_msd_core_model (.REF_CLK(clk), .RST(rst),
        .CPU_STALL(stall), .evt_kind(kind), .evt_req(evt_req), .DBG(dbg),
        .CORE(core));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Flash reads must follow one another with no gap or repeat
    always @(posedge clk) begin
        if (flash_rd === 1'b1) begin
            if (seq && flash_addr !== last_a + 24'h1) fail("address skip");
            last_a = flash_addr;
            seq = 1'b1;
            n_rd++;
        end
    end
    task automatic fail(input string m);
        n_fail++;
        $display("unexpected at %0t: %s", $time, m);
    endtask
    task automatic chk(input logic [31:0] got, exp, input string m);
        checks_done++;
        if (got !== exp) fail(m);
    endtask
    task automatic results();
        $display("comparisons %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // One APB transfer; read data is taken at the access edge
    task automatic apb(input logic w, input logic [11:0] idx,
                       input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        pwr <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            fail("bus hang");
            results();
        end
        err = pslverr;
        rdat = prdata;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask
    task automatic rd(input logic [11:0] idx);
        apb(1'b0, idx, 32'h0);
    endtask
    task automatic start(input logic [1:0] m, input logic [23:0] lo);
        seq = 1'b0;
        wr(IDX_CRC_CTRL, 32'h000000C0);
        wr(IDX_SCAN_START, {8'h00, lo});
        wr(IDX_SCAN_END, {8'h00, lo + 24'h0000FF});
        wr(IDX_SCAN_CTRL, {24'h000000, 6'h30, m});
    endtask
    task automatic wait_rd();
        n0 = n_rd;
        for (int i = 0; i < 300 && n_rd == n0; i++) @(posedge clk);
        if (n_rd == n0) begin
            fail("no flash read");
            results();
        end
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(IDX_SCAN_CTRL);
        chk(rdat, {24'h0, SCAN_CTRL_RST}, "scanner control reset");
        rd(IDX_CRC_POLY);
        chk(rdat, {16'h0, POLY_RST}, "polynomial reset");
        rd(12'hF70);
        chk({rdat[30:0], err}, 32'h1, "unmapped access");
        wr(IDX_IRQ_MASK, 32'h1);
        for (int m = 0; m < 4; m++) begin
            start(m[1:0], 24'h000100);
            trig <= 1'b1;
            wait_rd();
            chk({8'h0, last_a}, 32'h100, "first address");
            wr(IDX_SCAN_CTRL, 32'h80);
            trig <= 1'b0;
            wr(IDX_IRQ_STAT, 32'h3);
        end
        $display("test modes done");
        for (int m = 0; m < 2; m++) begin
            start(m[1:0], 24'h000200);
            for (int k = 0; k < 5 - 4 * m; k++) begin
                wait_rd();
                kind <= k[2:0];
                evt_req <= 1'b1;
                @(posedge clk);
                evt_req <= 1'b0;
                repeat (3) @(posedge clk);
                n0 = n_rd;
                a0 = flash_addr;
                rd(IDX_SCAN_CTRL);
                chk(rdat & 32'hC3, 32'hC0 | m, "state in debug");
                for (int i = 0; i < 99 && dbg.in_debug === 1'b1; i++)
                    @(posedge clk);
                chk(n_rd, n0, "read during debug");
                chk({8'h0, flash_addr}, {8'h0, a0}, "address moved");
            end
            for (int i = 0; i < 2000 && irq !== 1'b1; i++) @(posedge clk);
            chk(irq, 1'b1, "no done interrupt");
            rd(IDX_SCAN_CTRL);
            chk(rdat[SC_GO], 1'b0, "go not cleared");
            wr(IDX_IRQ_MASK, 32'h0);
            chk(irq, 1'b0, "masked interrupt");
            wr(IDX_IRQ_MASK, 32'h1);
            wr(IDX_IRQ_STAT, 32'h3);
            chk(irq, 1'b0, "interrupt not cleared");
        end
        $display("test debug done");
        impl <= 1'b0;
        start(2'b00, 24'h000300);
        wait_rd();
        repeat (4) @(posedge clk);
        chk(irq, 1'b1, "no done at unimplemented");
        impl <= 1'b1;
        wr(IDX_IRQ_STAT, 32'h3);
        wr(IDX_MOD_DIS, 32'h2);
        start(2'b00, 24'h000100);
        n0 = n_rd;
        repeat (50) @(posedge clk);
        chk(n_rd, n0, "disabled scanner read");
        wr(IDX_SCAN_CTRL, 32'h0);
        wr(IDX_MOD_DIS, 32'h0);
        allow <= 1'b0;
        start(2'b00, 24'h000100);
        repeat (50) @(posedge clk);
        chk(n_rd, n0, "unavailable scanner read");
        $display("test disable done");
        results();
    end
endmodule
`default_nettype wire
